// ==== src/dce_map.vh ====
`ifndef DCE_MAP_VH
`define DCE_MAP_VH

// printed offsets, kept as register indices; byte address = 4 * index
`define DCE_IDX_NEIGHBOUR_INDEX 32'h5000353e
`define DCE_IDX_SRC_START_LOW   32'h50003540
`define DCE_IDX_SRC_START_HIGH  32'h50003542
`define DCE_IDX_DST_START_LOW   32'h50003544
`define DCE_IDX_DST_START_HIGH  32'h50003546
`define DCE_IDX_INTERRUPT_POINT 32'h50003548
`define DCE_IDX_TRANSFER_LENGTH 32'h5000354a
`define DCE_IDX_CHANNEL_CONTROL 32'h5000354c
`define DCE_IDX_ITEM_INDEX      32'h5000354e
`define DCE_IDX_CHANNEL_STATUS  32'h50003550

// decoded window of the index bits
`define DCE_IDX_BITS 10

// channel_control fields
`define DCE_CTRL_ENABLE       0
`define DCE_CTRL_WIDTH_LO     1
`define DCE_CTRL_WIDTH_HI     2
`define DCE_CTRL_IRQ_ENABLE   3
`define DCE_CTRL_TRIGGER_MODE 4
`define DCE_CTRL_DST_INC      5
`define DCE_CTRL_SRC_INC      6
`define DCE_CTRL_CIRCULAR     7
`define DCE_CTRL_PRIO_LO      8
`define DCE_CTRL_PRIO_HI      10
`define DCE_CTRL_IDLE         11
`define DCE_CTRL_FILL         12
`define DCE_CTRL_SENSE        13
`define DCE_CTRL_WMASK        16'h3fff
`define DCE_CTRL_RESET        16'h0000

// item widths
`define DCE_WIDTH_BYTE 2'h0
`define DCE_WIDTH_HALF 2'h1
`define DCE_WIDTH_WORD 2'h2

// axi responses
`define DCE_RESP_OKAY   2'h0
`define DCE_RESP_SLVERR 2'h2

`endif

// ==== src/dce_channel.v ====
//
// Overview of operation
// - item index is read-only, counts stored items, returns to zero after completion.
// - next source and destination addresses come from starts, index, increments, width.
// - source start address is two writable 16-bit halves.
// - destination start address is two writable 16-bit halves.
// - after each item, before index advances, interrupt fires when point equals index.
// - interrupt only produced while the interrupt enable bit is one.
// - length field holds item count minus one.
// - sense bit picks level (0) or rising-edge (1) peripheral request detection.
// - fill mode reads source once and writes it to every destination item.
// - a fill transfer is not pre-empted by other channels until done.
// - idle bit zero copies back-to-back and holds the bus from lower masters.
// - idle bit one adds one wait cycle after each store but the last; ignored in trigger mode and in fill mode.
// - 3-bit priority, larger wins, 000 lowest and 111 highest.
// - equal priorities grant the lower channel number first.
// - normal mode stops after the length and clears the enable bit itself.
// - circular mode with trigger resets index and restarts; enable stays set.
// - source increment advances by 1, 2 or 4 per item, else fixed.
// - destination increment advances by 1, 2 or 4 per item, else fixed.
// - trigger bit zero starts at once, one waits for each peripheral request.
// - width field 00 byte, 01 halfword, 10 word, 11 reserved.
// - enable bit one turns channel on; zero keeps it off and frozen.
`timescale 1ns/1ns
`include "dce_map.vh"

module dce_channel #(
	parameter [2:0] CHANNEL_NUMBER = 3'h4
) (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// system bus master
	output reg         bus_request,
	output reg         bus_hold,
	output reg  [2:0]  bus_priority,
	output reg  [2:0]  bus_channel,
	input  wire        bus_grant,
	output reg         bus_valid,
	output reg         bus_write,
	output reg  [1:0]  bus_size,
	output reg  [31:0] bus_addr,
	output reg  [31:0] bus_wdata,
	input  wire [31:0] bus_rdata,
	input  wire        bus_ready,
	// peripheral request, neighbour index, interrupt
	input  wire        periph_request,
	input  wire [15:0] neighbour_item_index,
	output reg         channel_irq
);

	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_WAIT  = 3'h1;
	localparam [2:0] ST_ARB   = 3'h2;
	localparam [2:0] ST_READ  = 3'h3;
	localparam [2:0] ST_WRITE = 3'h4;
	localparam [2:0] ST_GAP   = 3'h5;

	// full indices overflow a byte address, so only the low index bits are decoded
	localparam [31:0] IDX_MASK = (32'h0000_0001 << `DCE_IDX_BITS) - 32'h0000_0001;
	localparam [31:0] A_NEIGH  = `DCE_IDX_NEIGHBOUR_INDEX & IDX_MASK;
	localparam [31:0] A_SRCL   = `DCE_IDX_SRC_START_LOW & IDX_MASK;
	localparam [31:0] A_SRCH   = `DCE_IDX_SRC_START_HIGH & IDX_MASK;
	localparam [31:0] A_DSTL   = `DCE_IDX_DST_START_LOW & IDX_MASK;
	localparam [31:0] A_DSTH   = `DCE_IDX_DST_START_HIGH & IDX_MASK;
	localparam [31:0] A_INTP   = `DCE_IDX_INTERRUPT_POINT & IDX_MASK;
	localparam [31:0] A_LEN    = `DCE_IDX_TRANSFER_LENGTH & IDX_MASK;
	localparam [31:0] A_CTRL   = `DCE_IDX_CHANNEL_CONTROL & IDX_MASK;
	localparam [31:0] A_INDEX  = `DCE_IDX_ITEM_INDEX & IDX_MASK;
	localparam [31:0] A_STAT   = `DCE_IDX_CHANNEL_STATUS & IDX_MASK;

	////////////////////////////////////////////////////////////////////////////////
	// registers

	reg  [15:0] source_start_low;
	reg  [15:0] source_start_high;
	reg  [15:0] destination_start_low;
	reg  [15:0] destination_start_high;
	reg  [15:0] interrupt_point;
	reg  [15:0] transfer_length;
	reg  [15:0] channel_control;
	reg  [15:0] item_index;
	reg  [2:0]  state;
	reg  [31:0] held_data;
	reg         fill_loaded;
	reg         request_prev;
	reg         request_pending;
	reg         done_clear;

	// axi write side bookkeeping
	reg         aw_taken;
	reg         w_taken;
	reg  [31:0] aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;

	wire        ch_enable   = channel_control[`DCE_CTRL_ENABLE];
	wire [1:0]  item_width  = channel_control[`DCE_CTRL_WIDTH_HI:`DCE_CTRL_WIDTH_LO];
	wire        irq_enable  = channel_control[`DCE_CTRL_IRQ_ENABLE];
	wire        request_trigger_mode = channel_control[`DCE_CTRL_TRIGGER_MODE];
	wire        destination_increment_enable = channel_control[`DCE_CTRL_DST_INC];
	wire        source_increment_enable = channel_control[`DCE_CTRL_SRC_INC];
	wire        circular    = channel_control[`DCE_CTRL_CIRCULAR];
	wire [2:0]  channel_priority = channel_control[`DCE_CTRL_PRIO_HI:`DCE_CTRL_PRIO_LO];
	wire        idle_mode   = channel_control[`DCE_CTRL_IDLE];
	wire        fill_mode   = channel_control[`DCE_CTRL_FILL];
	wire        edge_sense  = channel_control[`DCE_CTRL_SENSE];

	////////////////////////////////////////////////////////////////////////////////
	// address generation

	reg  [31:0] offset;
	reg  [31:0] next_src;
	reg  [31:0] next_dst;

	always @*
	begin
		// index scaled by item size; 11 is reserved, treated as a byte
		case (item_width)
			`DCE_WIDTH_HALF: offset = {15'h0000, item_index, 1'b0};
			`DCE_WIDTH_WORD: offset = {14'h0000, item_index, 2'b00};
			default:         offset = {16'h0000, item_index};
		endcase
		// fill mode reads one fixed source item
		next_src = {source_start_high, source_start_low} +
			((source_increment_enable && !fill_mode) ? offset : 32'h0000_0000);
		next_dst = {destination_start_high, destination_start_low} +
			(destination_increment_enable ? offset : 32'h0000_0000);
	end

	// a trigger is a level or a rising edge caught earlier
	wire request_seen = edge_sense ? request_pending : periph_request;
	wire last_item    = (item_index == transfer_length);
	wire active       = (state != ST_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// register bus

	wire        do_write   = aw_taken && w_taken && !s_axi_bvalid;
	wire [31:0] wr_index   = {22'h00_0000, aw_addr[11:2]};
	wire [31:0] rd_index   = {22'h00_0000, s_axi_araddr[11:2]};
	wire [15:0] wr_mask    = {{8{w_strb[1]}}, {8{w_strb[0]}}};

	reg         wr_hit;
	reg         rd_hit;
	reg  [15:0] rd_value;

	always @*
	begin
		case (wr_index)
			A_SRCL, A_SRCH, A_DSTL, A_DSTH, A_INTP, A_LEN, A_CTRL,
			A_NEIGH, A_INDEX, A_STAT: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		rd_hit = 1'b1;
		case (rd_index)
			A_NEIGH: rd_value = neighbour_item_index;
			A_SRCL:  rd_value = source_start_low;
			A_SRCH:  rd_value = source_start_high;
			A_DSTL:  rd_value = destination_start_low;
			A_DSTH:  rd_value = destination_start_high;
			A_INTP:  rd_value = interrupt_point;
			A_LEN:   rd_value = transfer_length;
			A_CTRL:  rd_value = channel_control & `DCE_CTRL_WMASK;
			A_INDEX: rd_value = item_index;
			A_STAT:  rd_value = {13'h0000, state};
			default:
			begin
				rd_value = 16'h0000;
				rd_hit   = 1'b0;
			end
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DCE_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `DCE_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			aw_taken      <= 1'b0;
			w_taken       <= 1'b0;
			aw_addr       <= 32'h0000_0000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end
		else
		begin
			// ready pulses for one cycle, then waits for the pair to finish
			s_axi_awready <= !aw_taken && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_taken && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_taken <= 1'b1;
				aw_addr  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_taken <= 1'b1;
				w_data  <= s_axi_wdata;
				w_strb  <= s_axi_wstrb;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `DCE_RESP_OKAY : `DCE_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_taken     <= 1'b0;
				w_taken      <= 1'b0;
			end
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {16'h0000, rd_value};
				s_axi_rresp  <= rd_hit ? `DCE_RESP_OKAY : `DCE_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// software side of the register file; the engine only clears enable
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			source_start_low       <= 16'h0000;
			source_start_high      <= 16'h0000;
			destination_start_low  <= 16'h0000;
			destination_start_high <= 16'h0000;
			interrupt_point        <= 16'h0000;
			transfer_length        <= 16'h0000;
			channel_control        <= `DCE_CTRL_RESET;
		end
		else
		begin
			if (do_write)
			begin
				case (wr_index)
					A_SRCL: source_start_low <= (source_start_low & ~wr_mask) |
						(w_data[15:0] & wr_mask);
					A_SRCH: source_start_high <= (source_start_high & ~wr_mask) |
						(w_data[15:0] & wr_mask);
					A_DSTL: destination_start_low <= (destination_start_low & ~wr_mask) |
						(w_data[15:0] & wr_mask);
					A_DSTH: destination_start_high <= (destination_start_high & ~wr_mask) |
						(w_data[15:0] & wr_mask);
					A_INTP: interrupt_point <= (interrupt_point & ~wr_mask) |
						(w_data[15:0] & wr_mask);
					A_LEN: transfer_length <= (transfer_length & ~wr_mask) |
						(w_data[15:0] & wr_mask);
					A_CTRL: channel_control <= ((channel_control & ~wr_mask) |
						(w_data[15:0] & wr_mask)) & `DCE_CTRL_WMASK;
					default: ;
				endcase
			end
			// a software write in the same cycle takes precedence
			if (done_clear && !(do_write && wr_index == A_CTRL))
				channel_control[`DCE_CTRL_ENABLE] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transfer engine

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state           <= ST_IDLE;
			item_index      <= 16'h0000;
			held_data       <= 32'h0000_0000;
			fill_loaded     <= 1'b0;
			request_prev    <= 1'b0;
			request_pending <= 1'b0;
			done_clear      <= 1'b0;
			bus_request     <= 1'b0;
			bus_hold        <= 1'b0;
			bus_priority    <= 3'h0;
			bus_channel     <= 3'h0;
			bus_valid       <= 1'b0;
			bus_write       <= 1'b0;
			bus_size        <= `DCE_WIDTH_BYTE;
			bus_addr        <= 32'h0000_0000;
			bus_wdata       <= 32'h0000_0000;
			channel_irq     <= 1'b0;
		end
		else
		begin
			done_clear   <= 1'b0;
			channel_irq  <= 1'b0;
			request_prev <= periph_request;
			bus_priority <= channel_priority;
			bus_channel  <= CHANNEL_NUMBER;
			// fill and blocking transfers keep the bus between items
			bus_hold <= active && ch_enable &&
				(fill_mode || (!idle_mode && !request_trigger_mode));
			// an edge arriving while the pending flag is consumed is kept
			if (periph_request && !request_prev && edge_sense)
				request_pending <= 1'b1;
			else if (state == ST_WAIT && request_pending)
				request_pending <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					// disabled channel stays frozen here
					fill_loaded <= 1'b0;
					if (ch_enable && !done_clear)
					begin
						state       <= request_trigger_mode ? ST_WAIT : ST_ARB;
						bus_request <= !request_trigger_mode;
					end
				end
				ST_WAIT:
				begin
					if (!ch_enable)
					begin
						state      <= ST_IDLE;
						item_index <= 16'h0000;
					end
					else if (request_seen)
					begin
						state       <= ST_ARB;
						bus_request <= 1'b1;
					end
				end
				ST_ARB:
				begin
					if (!ch_enable)
					begin
						state       <= ST_IDLE;
						bus_request <= 1'b0;
						item_index  <= 16'h0000;
					end
					else if (bus_grant)
					begin
						bus_valid <= 1'b1;
						bus_size  <= item_width;
						if (fill_mode && fill_loaded)
						begin
							state     <= ST_WRITE;
							bus_write <= 1'b1;
							bus_addr  <= next_dst;
							bus_wdata <= held_data;
						end
						else
						begin
							state     <= ST_READ;
							bus_write <= 1'b0;
							bus_addr  <= next_src;
						end
					end
				end
				ST_READ:
				begin
					if (bus_ready)
					begin
						state       <= ST_WRITE;
						held_data   <= bus_rdata;
						fill_loaded <= 1'b1;
						bus_write   <= 1'b1;
						bus_addr    <= next_dst;
						bus_wdata   <= bus_rdata;
					end
				end
				ST_WRITE:
				begin
					if (bus_ready)
					begin
						bus_valid <= 1'b0;
						bus_write <= 1'b0;
						// checked against the index before it moves
						channel_irq <= irq_enable && (interrupt_point == item_index);
						if (last_item)
						begin
							item_index  <= 16'h0000;
							fill_loaded <= 1'b0;
							if (circular && request_trigger_mode && ch_enable)
							begin
								state       <= ST_WAIT;
								bus_request <= 1'b0;
							end
							else
							begin
								state       <= ST_IDLE;
								bus_request <= 1'b0;
								done_clear  <= 1'b1;
							end
						end
						else
						begin
							item_index <= item_index + 16'h0001;
							if (request_trigger_mode)
							begin
								state       <= ST_WAIT;
								bus_request <= 1'b0;
							end
							else if (idle_mode && !fill_mode)
							begin
								state       <= ST_GAP;
								bus_request <= 1'b0;
							end
							else
								state <= ST_ARB;
						end
					end
				end
				ST_GAP:
				begin
					// one free cycle for the processor or cache
					state       <= ST_ARB;
					bus_request <= 1'b1;
				end
				default:
				begin
					state       <= ST_IDLE;
					bus_request <= 1'b0;
					bus_valid   <= 1'b0;
				end
			endcase
		end
	end

endmodule

// ==== tb/dce_channel_assertions.sv ====
`timescale 1ns/1ns
module dce_channel_assertions #(
	parameter [2:0] CHANNEL_NUMBER = 3'h4
) (
	// clock and reset
	input wire        aclk,
	input wire        aresetn,
	// register bus handshakes
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	// system bus
	input wire        bus_request,
	input wire        bus_grant,
	input wire        bus_valid,
	input wire        bus_write,
	input wire [1:0]  bus_size,
	input wire [31:0] bus_addr,
	input wire        bus_ready,
	input wire [2:0]  bus_channel,
	input wire        channel_irq
);
	reg wr_done_q;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	always @(posedge aclk)
		wr_done_q <= aresetn && bus_valid && bus_write && bus_ready;

	sequence read_done;
		bus_valid && !bus_write && bus_ready;
	endsequence
	sequence write_start;
		bus_valid && bus_write;
	endsequence

	////////////////////////////////////////////////////////////////////////
	beat_hold_a: assert property (bus_valid && !bus_ready |=> bus_valid && $stable(bus_addr))
		else $error("bus beat changed before ready");
	grant_first_a: assert property ($rose(bus_valid) |-> $past(bus_grant))
		else $error("bus beat started without grant");
	read_write_a: assert property (read_done |=> write_start)
		else $error("read beat not followed by write");
	valid_req_a: assert property (bus_valid |-> bus_request)
		else $error("bus beat without request");
	size_legal_a: assert property (bus_valid |-> bus_size != 2'h3)
		else $error("reserved item width on bus");
	irq_cause_a: assert property (channel_irq |-> wr_done_q)
		else $error("interrupt without completed store");
	irq_pulse_a: assert property (channel_irq |=> !channel_irq)
		else $error("interrupt longer than one cycle");
	channel_id_a: assert property (bus_request |-> bus_channel == CHANNEL_NUMBER)
		else $error("wrong channel number on bus");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	read_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not released");
	write_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	item_cover: cover property (read_done ##1 write_start);
endmodule

bind dce_channel dce_channel_assertions #(.CHANNEL_NUMBER(CHANNEL_NUMBER)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .bus_request(bus_request),
	.bus_grant(bus_grant), .bus_valid(bus_valid), .bus_write(bus_write), .bus_size(bus_size),
	.bus_addr(bus_addr), .bus_ready(bus_ready), .bus_channel(bus_channel),
	.channel_irq(channel_irq));

// ==== tb/dce_bus_model.sv ====
`timescale 1ns/1ns
module dce_bus_model (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// pacing
	input  wire        slow,
	// system bus
	input  wire        bus_request,
	output reg         bus_grant,
	input  wire        bus_valid,
	input  wire        bus_write,
	input  wire [31:0] bus_addr,
	output reg  [31:0] bus_rdata,
	output reg         bus_ready
);
	function [31:0] mem_word(input [31:0] a);
		mem_word = {a[15:0] ^ 16'ha5c3, a[15:0] ^ 16'h3c5a};
	endfunction

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bus_grant <= 1'b0;
			bus_ready <= 1'b0;
			bus_rdata <= 32'h0;
		end
		else
		begin
			// other masters may hold the bus a while when slow
			bus_grant <= bus_request && (bus_grant || !slow || ($urandom % 4 == 0));
			bus_ready <= 1'b0;
			// released data toggles so stale data never passes as valid
			bus_rdata <= ~bus_rdata;
			if (bus_valid && !bus_ready && (!slow || ($urandom % 3 == 0)))
			begin
				bus_ready <= 1'b1;
				if (!bus_write)
					bus_rdata <= mem_word(bus_addr);
			end
		end
	end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`include "dce_map.vh"
module tb_top;
	reg         aclk, aresetn, slow, periph_request;
	reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, m_src, m_dst, last_rd;
	reg  [3:0]  s_axi_wstrb;
	reg  [15:0] neighbour_item_index, m_ctl, m_len, rd, ctl;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp, bus_size;
	wire [31:0] s_axi_rdata, bus_addr, bus_wdata, bus_rdata;
	wire        bus_request, bus_hold, bus_grant, bus_valid, bus_write, bus_ready, channel_irq;
	wire [2:0]  bus_priority, bus_channel;
	integer     n_errors, total_checks, item, irq_cnt, req_seen, i, n, drops, req_q;

	dce_channel u_dce_channel (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .bus_request(bus_request), .bus_hold(bus_hold),
		.bus_priority(bus_priority), .bus_channel(bus_channel), .bus_grant(bus_grant),
		.bus_valid(bus_valid), .bus_write(bus_write), .bus_size(bus_size),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.bus_ready(bus_ready), .periph_request(periph_request),
		.neighbour_item_index(neighbour_item_index), .channel_irq(channel_irq));

	dce_bus_model u_dce_bus_model (
		.aclk(aclk), .aresetn(aresetn), .slow(slow), .bus_request(bus_request),
		.bus_grant(bus_grant), .bus_valid(bus_valid), .bus_write(bus_write),
		.bus_addr(bus_addr), .bus_rdata(bus_rdata), .bus_ready(bus_ready));

	always #5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////
	task check(input [31:0] seen, input [31:0] exp);
	begin
		total_checks = total_checks + 1;
		if (seen !== exp)
		begin
			n_errors = n_errors + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task close_out;
	begin
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask

	// register index to byte address is four times the index
	task axi_wr(input [31:0] idx, input [15:0] d, input [1:0] er);
	begin
		s_axi_awaddr <= idx << 2;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		check(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	end
	endtask

	task axi_rd(input [31:0] idx, input [1:0] er, output [15:0] d);
	begin
		s_axi_araddr <= idx << 2;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		check(s_axi_rresp, er);
		d = s_axi_rdata[15:0];
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	end
	endtask

	function [31:0] xaddr(input [31:0] base, input inc);
		xaddr = base + (inc ? (item % (m_len + 1)) << m_ctl[2:1] : 32'h0);
	endfunction

	////////////////////////////////////////////////////////////////////////
	always @(posedge aclk)
	begin
		if (bus_request)
			req_seen = 1;
		if (channel_irq)
			irq_cnt = irq_cnt + 1;
		if (req_q && !bus_request)
			drops = drops + 1;
		req_q = bus_request;
		if (bus_valid && bus_ready)
		begin
			check(bus_size, m_ctl[2:1]);
			check(bus_priority, m_ctl[10:8]);
			check(bus_hold, m_ctl[12] || (!m_ctl[11] && !m_ctl[4]));
			if (!bus_write)
			begin
				if (m_ctl[12])
					check(item, 0);
				check(bus_addr, xaddr(m_src, m_ctl[6] && !m_ctl[12]));
				last_rd = bus_rdata;
			end
			else
			begin
				check(bus_addr, xaddr(m_dst, m_ctl[5]));
				check(bus_wdata, last_rd);
				item = item + 1;
			end
		end
	end

	task run(input [15:0] c, input [15:0] len, input [15:0] pt);
	begin
		m_src = $urandom & 32'hfffffffc;
		m_dst = $urandom & 32'hfffffffc;
		{m_ctl, m_len, item, irq_cnt, drops} = {c, len, 96'h0};
		axi_wr(`DCE_IDX_SRC_START_LOW, m_src[15:0], `DCE_RESP_OKAY);
		axi_wr(`DCE_IDX_SRC_START_HIGH, m_src[31:16], `DCE_RESP_OKAY);
		axi_wr(`DCE_IDX_DST_START_LOW, m_dst[15:0], `DCE_RESP_OKAY);
		axi_wr(`DCE_IDX_DST_START_HIGH, m_dst[31:16], `DCE_RESP_OKAY);
		axi_wr(`DCE_IDX_INTERRUPT_POINT, pt, `DCE_RESP_OKAY);
		axi_wr(`DCE_IDX_TRANSFER_LENGTH, len, `DCE_RESP_OKAY);
		axi_wr(`DCE_IDX_CHANNEL_CONTROL, c, `DCE_RESP_OKAY);
		rd = 16'h1;
		for (n = 0; rd[0] && n < 100; n = n + 1)
			axi_rd(`DCE_IDX_CHANNEL_CONTROL, `DCE_RESP_OKAY, rd);
		check(rd, c & 16'hfffe);
		check(item, len + 1);
		check(irq_cnt, (c[3] && pt <= len) ? 1 : 0);
		check(drops, (c[11] && !c[12]) ? len + 1 : 1);
		axi_rd(`DCE_IDX_ITEM_INDEX, `DCE_RESP_OKAY, rd);
		check(rd, 16'h0);
	end
	endtask

	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{slow, periph_request, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 98'h0;
		{s_axi_wstrb, neighbour_item_index, m_ctl, m_len} = {4'hf, 48'h0};
		{n_errors, total_checks, item, irq_cnt, req_seen, drops, req_q} = 224'h0;
		{m_src, m_dst, last_rd} = 96'h0;
		rd = $urandom(89486);
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset values from the neighbour index up to the status word
		for (i = 0; i < 10; i = i + 1)
		begin
			axi_rd(`DCE_IDX_NEIGHBOUR_INDEX + 2 * i, `DCE_RESP_OKAY, rd);
			check(rd, 16'h0);
		end
		for (i = 1; i < 7; i = i + 1)
		begin
			ctl = $urandom;
			axi_wr(`DCE_IDX_NEIGHBOUR_INDEX + 2 * i, ctl, `DCE_RESP_OKAY);
			axi_rd(`DCE_IDX_NEIGHBOUR_INDEX + 2 * i, `DCE_RESP_OKAY, rd);
			check(rd, ctl);
		end
		neighbour_item_index <= 16'hc35a;
		axi_wr(`DCE_IDX_NEIGHBOUR_INDEX, 16'h1111, `DCE_RESP_OKAY);
		axi_rd(`DCE_IDX_NEIGHBOUR_INDEX, `DCE_RESP_OKAY, rd);
		check(rd, 16'hc35a);
		axi_wr(`DCE_IDX_ITEM_INDEX, 16'h1234, `DCE_RESP_OKAY);
		axi_rd(`DCE_IDX_ITEM_INDEX, `DCE_RESP_OKAY, rd);
		check(rd, 16'h0);
		axi_wr(`DCE_IDX_CHANNEL_CONTROL, 16'hfffe, `DCE_RESP_OKAY);
		axi_rd(`DCE_IDX_CHANNEL_CONTROL, `DCE_RESP_OKAY, rd);
		check(rd, 16'h3ffe);
		axi_wr(`DCE_IDX_CHANNEL_CONTROL, 16'h0, `DCE_RESP_OKAY);
		// byte strobes: only the high byte of the interrupt point changes
		axi_wr(`DCE_IDX_INTERRUPT_POINT, 16'ha5a5, `DCE_RESP_OKAY);
		s_axi_wstrb <= 4'h2;
		axi_wr(`DCE_IDX_INTERRUPT_POINT, 16'h3c3c, `DCE_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		axi_rd(`DCE_IDX_INTERRUPT_POINT, `DCE_RESP_OKAY, rd);
		check(rd, 16'h3ca5);
		axi_wr(32'h50003580, 16'h5555, `DCE_RESP_SLVERR);
		axi_rd(32'h50003580, `DCE_RESP_SLVERR, rd);
		check(rd, 16'h0);
		// free-running transfers of every width, fill among them
		for (i = 0; i < 14; i = i + 1)
		begin
			slow <= i[0];
			ctl = ($urandom & 16'h0f6f) | 16'h0001;
			if (i < 3)
				ctl[2:1] = i[1:0];
			if (ctl[2:1] == 2'h3)
				ctl[2:1] = `DCE_WIDTH_WORD;
			if ($urandom % 4 == 0)
				ctl = ctl | 16'h1020;
			run(ctl, (i == 0) ? 16'h0 : $urandom % 5, $urandom % 6);
		end
		// fixed 60-cycle windows below need a bus without random stalls
		slow <= 1'b0;
		// edge-sensed trigger: one item per rising edge of the request
		{m_ctl, m_len, item, req_seen} = {16'h2075, 16'h2, 32'h0, 32'h0};
		axi_wr(`DCE_IDX_TRANSFER_LENGTH, 16'h2, `DCE_RESP_OKAY);
		axi_wr(`DCE_IDX_CHANNEL_CONTROL, 16'h2075, `DCE_RESP_OKAY);
		repeat (20) @(posedge aclk);
		check(req_seen, 0);
		for (i = 0; i < 3; i = i + 1)
		begin
			periph_request <= 1'b1;
			repeat (60) @(posedge aclk);
			check(item, i + 1);
			periph_request <= 1'b0;
			@(posedge aclk);
		end
		axi_rd(`DCE_IDX_CHANNEL_CONTROL, `DCE_RESP_OKAY, rd);
		check(rd, 16'h2074);
		// level trigger in circular mode keeps the channel enabled
		{m_ctl, m_len, item} = {16'h00f5, 16'h1, 32'h0};
		axi_wr(`DCE_IDX_TRANSFER_LENGTH, 16'h1, `DCE_RESP_OKAY);
		axi_wr(`DCE_IDX_CHANNEL_CONTROL, 16'h00f5, `DCE_RESP_OKAY);
		periph_request <= 1'b1;
		for (n = 0; item < 5 && n < 500; n = n + 1)
			@(posedge aclk);
		periph_request <= 1'b0;
		repeat (40) @(posedge aclk);
		axi_rd(`DCE_IDX_CHANNEL_CONTROL, `DCE_RESP_OKAY, rd);
		check(rd, 16'h00f5);
		axi_wr(`DCE_IDX_CHANNEL_CONTROL, 16'h0, `DCE_RESP_OKAY);
		close_out;
	end

	initial
	begin
		repeat (60000) @(posedge aclk);
		n_errors = n_errors + 1;
		close_out;
	end
endmodule
